// ==== hw/seq_ext_regs.vh ====
// Constants for the sequencer external interface: offsets, layouts, timing.
// Assumes a 40 MHz ref_clk and a byte-addressed word register port.
`ifndef SEQ_EXT_REGS_VH
`define SEQ_EXT_REGS_VH

// Register byte addresses
`define ADDR_PRESET 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_MASTER 8'h08
`define ADDR_SEQ 8'h0c
`define ADDR_LASTQC 8'h10
`define ADDR_W 8

// Reset values
`define PRESET_RST 26'h0000000

// Counter widths (stages)
`define MT_W 26
`define ST_W 18

// Quantitative command word layout
`define QC_W 13
`define TAG_MSB 7
`define DEST_MSB 10
`define DEST_LSB 8
`define BURN_BIT 11
`define DEST_SEQ 3'h7
`define SLOTS 4
`define NDEST 7

// Status register bit positions
`define ST_SCAN 0
`define ST_ENABLED 1
`define ST_BURNARM 2
`define ST_SEPINH 3
`define ST_CNTINH 4
`define ST_SUPINH 5
`define ST_SEQRUN 6

// Timing
`define CLK_HZ 40000000
`define CLOSE_MS 200
// 200 ms at 40 MHz, sized to the closure counter
`define CLOSE_CYC 23'd8000000
`define CLOSE_CW 23
// Oscillator step: 2^32 * 153600 / 40e6, truncated
`define NCO_INC 32'h00fba882
// 153600 oscillator cycles per second
`define CHAIN_LAST 18'h257ff
`define CHAIN_HALF 18'h12c00

`endif

// ==== hw/closure_pulse.v ====
// Fixed-length closure driver: one fire pulse gives one closure.
// Assumes fire is a one-cycle pulse on ref_clk; a new fire restarts it.
`timescale 1ns/1ps
`default_nettype none
`include "seq_ext_regs.vh"

module closure_pulse #(
    parameter [`CLOSE_CW-1:0] CYCLES = `CLOSE_CYC
) (
    input wire ref_clk, // System clock
    input wire arst_n, // Async reset, active low
    input wire fire, // Start a closure
    output reg close // Closure active
);

reg [`CLOSE_CW-1:0] cnt_reg;

// Close for exactly CYCLES cycles, then open
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        cnt_reg <= {`CLOSE_CW{1'b0}};
        close <= 1'b0;
    end else if (fire) begin
        cnt_reg <= CYCLES - 1'b1;
        close <= 1'b1;
    end else if (cnt_reg != {`CLOSE_CW{1'b0}}) begin
        cnt_reg <= cnt_reg - 1'b1;
    end else begin
        close <= 1'b0;
    end
end

endmodule
`default_nettype wire

// ==== hw/sequencer_external_interface.v ====
// External interface of the control and sequencer unit: pins to and from
// ground launch equipment, command receiver and subsystems.
// Assumes all pin inputs are asynchronous; the register port is on ref_clk.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "seq_ext_regs.vh"

module sequencer_external_interface #(
    parameter [`CLOSE_CW-1:0] CLOSE_CYCLES = `CLOSE_CYC
) (
    input wire ref_clk, // 40 MHz clock
    input wire arst_n, // Async reset, active low
    input wire [`ADDR_W-1:0] regAddr, // Register byte address
    input wire [31:0] regWrData, // Register write data
    input wire regWr, // Write strobe
    input wire regRd, // Read strobe
    output reg [31:0] regRdData, // Read data, cycle after strobe
    input wire countInhibitPin, // Ground: high freezes second counting of the main counter only; update pulses still count
    input wire presetPin, // Ground: preset pulse
    input wire updatePin, // Ground: update pulse train
    input wire supplyInhibitPin, // Ground: supply output inhibit
    input wire dcEnablePin, // Receiver: enable outputs
    input wire dcInhibitPin, // Receiver: inhibit outputs
    input wire dcScanPin, // Receiver: select memory scan
    input wire dcErasePin, // Receiver: erase invalid words
    input wire dcBurnPin, // Receiver: enable engine burn
    input wire qcStrobePin, // Receiver: quantitative word strobe
    input wire [`QC_W-1:0] qcWordPin, // Receiver: quantitative word
    input wire sepInhibitPin, // Separation connector inhibit
    output reg [`QC_W-1:0] qcFwdWord, // Word forwarded to ground
    output reg qcFwdStrobe, // Forward strobe, one cycle
    output wire [`NDEST-1:0] cmdClose, // Discrete command closures
    output wire eventClose, // Event indication closure
    output reg sq1pps, // 1 pps square wave
    output reg sq38k4, // 38.4 kc square wave
    output reg sq153k6, // 153.6 kc square wave
    output reg scanModeStat, // High in memory scan mode
    output reg outEnabledStat, // High while outputs enabled
    output reg supplyOff, // Supply output inhibit
    output reg [`MT_W-1:0] masterStages, // Main counter stages
    output reg [`ST_W-1:0] seqStages // Interval counter stages
);

// Mode state machine, one-hot
localparam [1:0] MODE_UPDATE = 2'b01;
localparam [1:0] MODE_SCAN = 2'b10;
localparam NPIN = 11;

reg [NPIN-1:0] syncA_reg;
reg [NPIN-1:0] syncB_reg;
reg [NPIN-1:0] syncC_reg;
reg [`QC_W-1:0] wordA_reg;
reg [`QC_W-1:0] wordB_reg;
wire [NPIN-1:0] pinsIn;
wire [NPIN-1:0] rise;
wire countInh;
wire presetEv;
wire updateEv;
wire enableEv;
wire inhibitEv;
wire scanEv;
wire eraseEv;
wire burnEv;
wire qcEv;
wire sepInh;
wire supInh;

reg [31:0] nco_reg;
reg ncoMsb_reg;
reg [17:0] chain_reg;
reg secTick_reg;
reg [`MT_W-1:0] preset_reg;
reg [1:0] mode_reg;
reg [1:0] mode_next;
reg enabled_reg;
reg burnArm_reg;
reg seqRun_reg;
reg [`QC_W-1:0] slot_reg [0:`SLOTS-1];
reg [`SLOTS-1:0] valid_reg;
reg [`SLOTS-1:0] valid_next;
reg [1:0] scanPtr_reg;
reg [`QC_W-1:0] lastQc_reg;
reg [`NDEST-1:0] fire_reg;
reg eventFire_reg;
reg [1:0] freeIdx;
reg freeAny;
reg [`QC_W-1:0] curWord;
reg hit;
reg allowed;
reg isBurn;
integer i;

assign pinsIn = {sepInhibitPin, qcStrobePin, dcBurnPin, dcErasePin, dcScanPin,
    dcInhibitPin, dcEnablePin, supplyInhibitPin, updatePin, presetPin,
    countInhibitPin};

// Two-stage synchronisers, third stage only for edge detection
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        syncA_reg <= {NPIN{1'b0}};
        syncB_reg <= {NPIN{1'b0}};
        syncC_reg <= {NPIN{1'b0}};
        wordA_reg <= {`QC_W{1'b0}};
        wordB_reg <= {`QC_W{1'b0}};
    end else begin
        syncA_reg <= pinsIn;
        syncB_reg <= syncA_reg;
        syncC_reg <= syncB_reg;
        wordA_reg <= qcWordPin;
        wordB_reg <= wordA_reg;
    end
end

// Pulses act on their rising edge, levels are used directly
assign rise = syncB_reg & ~syncC_reg;
assign countInh = syncB_reg[0];
assign presetEv = rise[1];
assign updateEv = rise[2];
assign supInh = syncB_reg[3];
assign enableEv = rise[4];
assign inhibitEv = rise[5];
assign scanEv = rise[6];
assign eraseEv = rise[7];
assign burnEv = rise[8];
assign qcEv = rise[9];
assign sepInh = syncB_reg[10];

// Common oscillator: accumulator MSB runs at 153.6 kc
// Fractional step keeps the long-term rate exact to within truncation
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        nco_reg <= 32'h00000000;
        ncoMsb_reg <= 1'b0;
        chain_reg <= 18'h00000;
        secTick_reg <= 1'b0;
    end else begin
        secTick_reg <= 1'b0;
        if (presetEv) begin
            nco_reg <= 32'h00000000;
            ncoMsb_reg <= 1'b0;
            chain_reg <= 18'h00000;
        end else begin
            nco_reg <= nco_reg + `NCO_INC;
            ncoMsb_reg <= nco_reg[31];
            if (nco_reg[31] && !ncoMsb_reg) begin
                if (chain_reg == `CHAIN_LAST) begin
                    chain_reg <= 18'h00000;
                    secTick_reg <= 1'b1;
                end else begin
                    chain_reg <= chain_reg + 18'h00001;
                end
            end
        end
    end
end

// Square-wave outputs, all derived from the common oscillator
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        sq153k6 <= 1'b0;
        sq38k4 <= 1'b0;
        sq1pps <= 1'b0;
    end else begin
        sq153k6 <= nco_reg[31];
        sq38k4 <= chain_reg[1];
        sq1pps <= (chain_reg < `CHAIN_HALF);
    end
end

// Main time counter and event interval counter
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        masterStages <= {`MT_W{1'b0}};
        seqStages <= {`ST_W{1'b0}};
        seqRun_reg <= 1'b0;
    end else begin
        if (presetEv) begin
            masterStages <= preset_reg;
        end else if (updateEv && secTick_reg && !countInh) begin
            masterStages <= masterStages + 26'h0000002;
        end else if (updateEv) begin
            masterStages <= masterStages + 26'h0000001;
        end else if (secTick_reg && !countInh) begin
            masterStages <= masterStages + 26'h0000001;
        end
        if (presetEv) begin
            seqStages <= {`ST_W{1'b0}};
            seqRun_reg <= 1'b0;
        end else begin
            if (hit && allowed && curWord[`DEST_MSB:`DEST_LSB] == `DEST_SEQ) begin
                seqRun_reg <= 1'b1;
                seqStages <= {`ST_W{1'b0}};
            end else if (seqRun_reg && secTick_reg) begin
                seqStages <= seqStages + 18'h00001;
            end
        end
    end
end

// Scan selection and store lookup
always @* begin
    freeAny = 1'b0;
    freeIdx = 2'h0;
    for (i = `SLOTS - 1; i >= 0; i = i - 1) begin
        if (!valid_reg[i]) begin
            freeAny = 1'b1;
            freeIdx = i[1:0];
        end
    end
    curWord = slot_reg[scanPtr_reg];
    isBurn = curWord[`BURN_BIT];
    hit = (mode_reg == MODE_SCAN) && valid_reg[scanPtr_reg]
        && (curWord[`TAG_MSB:0] == masterStages[`TAG_MSB:0]);
    // Only burns wait on the arm; others go out regardless
    allowed = enabled_reg && !sepInh && (!isBurn || burnArm_reg);
end

// Mode transitions
always @* begin
    case (mode_reg)
        MODE_UPDATE: begin
            if (scanEv) begin
                mode_next = MODE_SCAN;
            end else begin
                mode_next = MODE_UPDATE;
            end
        end
        MODE_SCAN: begin
            if (qcEv && !scanEv) begin
                mode_next = MODE_UPDATE;
            end else begin
                mode_next = MODE_SCAN;
            end
        end
        default: begin
            mode_next = MODE_UPDATE;
        end
    endcase
end

// Slot validity: erase, store and execute in one pass
always @* begin
    valid_next = valid_reg;
    if (eraseEv) begin
        for (i = 0; i < `SLOTS; i = i + 1) begin
            if (^slot_reg[i]) begin
                valid_next[i] = 1'b0;
            end
        end
    end
    if (hit) begin
        valid_next[scanPtr_reg] = 1'b0;
    end
    // A store lands on a free slot, never the hit one; it comes after the erase clears, so it wins
    if (qcEv && freeAny) begin
        valid_next[freeIdx] = 1'b1;
    end
end

// Store, forward and state flags
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        mode_reg <= MODE_UPDATE;
        enabled_reg <= 1'b0;
        burnArm_reg <= 1'b0;
        valid_reg <= {`SLOTS{1'b0}};
        scanPtr_reg <= 2'h0;
        lastQc_reg <= {`QC_W{1'b0}};
        qcFwdWord <= {`QC_W{1'b0}};
        qcFwdStrobe <= 1'b0;
        for (i = 0; i < `SLOTS; i = i + 1) begin
            slot_reg[i] <= {`QC_W{1'b0}};
        end
    end else begin
        mode_reg <= mode_next;
        valid_reg <= valid_next;
        scanPtr_reg <= scanPtr_reg + 2'h1;
        qcFwdStrobe <= qcEv;
        if (qcEv) begin
            qcFwdWord <= wordB_reg;
            lastQc_reg <= wordB_reg;
            if (freeAny) begin
                slot_reg[freeIdx] <= wordB_reg;
            end
        end
        if (enableEv) begin
            enabled_reg <= 1'b1;
        end else if (inhibitEv) begin
            enabled_reg <= 1'b0;
        end
        // Arm set wins over its consumption in the same cycle
        if (burnEv) begin
            burnArm_reg <= 1'b1;
        end else if (hit && allowed && isBurn) begin
            burnArm_reg <= 1'b0;
        end
    end
end

// Fire requests toward the closure drivers
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        fire_reg <= {`NDEST{1'b0}};
        eventFire_reg <= 1'b0;
    end else begin
        fire_reg <= {`NDEST{1'b0}};
        eventFire_reg <= 1'b0;
        if (hit && allowed) begin
            eventFire_reg <= 1'b1;
            if (curWord[`DEST_MSB:`DEST_LSB] != `DEST_SEQ) begin
                fire_reg[curWord[`DEST_MSB:`DEST_LSB]] <= 1'b1;
            end
        end
    end
end

// One closure driver per destination
genvar g;
generate
    for (g = 0; g < `NDEST; g = g + 1) begin : gDest
        closure_pulse #(
            .CYCLES(CLOSE_CYCLES)
        ) uClose (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .fire(fire_reg[g]),
            .close(cmdClose[g])
        );
    end
endgenerate

// Event indication closure
closure_pulse #(
    .CYCLES(CLOSE_CYCLES)
) uEvent (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .fire(eventFire_reg),
    .close(eventClose)
);

// Steady status lines
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        scanModeStat <= 1'b0;
        outEnabledStat <= 1'b0;
        supplyOff <= 1'b0;
    end else begin
        scanModeStat <= (mode_reg == MODE_SCAN);
        outEnabledStat <= enabled_reg;
        supplyOff <= supInh;
    end
end

// Register port: preset write, reads of state
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        preset_reg <= `PRESET_RST;
        regRdData <= 32'h00000000;
    end else begin
        regRdData <= 32'h00000000;
        if (regWr && regAddr == `ADDR_PRESET) begin
            preset_reg <= regWrData[`MT_W-1:0];
        end
        if (regRd) begin
            case (regAddr)
                `ADDR_PRESET: begin
                    regRdData <= {6'h00, preset_reg};
                end
                `ADDR_STATUS: begin
                    regRdData <= {25'h0000000, seqRun_reg, supInh, countInh,
                        sepInh, burnArm_reg, enabled_reg, mode_reg == MODE_SCAN};
                end
                `ADDR_MASTER: begin
                    regRdData <= {6'h00, masterStages};
                end
                `ADDR_SEQ: begin
                    regRdData <= {14'h0000, seqStages};
                end
                `ADDR_LASTQC: begin
                    regRdData <= {19'h00000, lastQc_reg};
                end
                default: begin
                    regRdData <= 32'h00000000;
                end
            endcase
        end
    end
end

endmodule
`default_nettype wire

// ==== test/sequencer_external_interface_props.sv ====
// Timing checks on the ports of the sequencer external interface.
// Assumes one clock domain and the closure length handed on by the bind.
`timescale 1ns/1ps
`default_nettype none
`include "seq_ext_regs.vh"

module sequencer_external_interface_props #(
    parameter [`CLOSE_CW-1:0] CLOSE_CYCLES = `CLOSE_CYC
) (
    input wire logic ref_clk, // Clock
    input wire logic arst_n, // Reset, active low
    input wire logic qcStrobePin, // Word strobe pin
    input wire logic qcFwdStrobe, // Forward strobe
    input wire logic [`NDEST-1:0] cmdClose, // Command closures
    input wire logic eventClose, // Event closure
    input wire logic sepInhibitPin, // Separation inhibit
    input wire logic dcScanPin, // Scan command pin
    input wire logic scanModeStat, // Scan status
    input wire logic dcEnablePin, // Enable command pin
    input wire logic dcInhibitPin, // Inhibit command pin
    input wire logic outEnabledStat, // Enabled status
    input wire logic countInhibitPin, // Count freeze level
    input wire logic presetPin, // Preset pin
    input wire logic updatePin, // Update pin
    input wire logic [`MT_W-1:0] masterStages, // Main counter
    input wire logic [`ST_W-1:0] seqStages, // Interval counter
    input wire logic sq153k6 // Fastest square wave
);
    logic [31:0] evtLen;
    logic [31:0] cmdLen;
    logic [7:0] sqHold;
    logic sqPrev;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // Run lengths; the wave counter catches a stuck or slow oscillator
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            evtLen <= 32'h0;
            cmdLen <= 32'h0;
            sqHold <= 8'h0;
            sqPrev <= 1'b0;
        end else begin
            evtLen <= eventClose ? evtLen + 32'h1 : 32'h0;
            cmdLen <= (|cmdClose) ? cmdLen + 32'h1 : 32'h0;
            // Preset restarts the oscillator, so the count restarts with it
            sqHold <= (sq153k6 != sqPrev || presetPin) ? 8'h1 : sqHold + 8'h1;
            sqPrev <= sq153k6;
        end
    end

    AST_FWD_ONE: assert property (
        qcFwdStrobe |=> !qcFwdStrobe) else $error("forward strobe longer than one cycle");
    AST_FWD_CAUSE: assert property (
        $rose(qcStrobePin) |-> ##[1:6] qcFwdStrobe) else $error("word not forwarded");
    AST_CMD_EVT: assert property (
        $rose(|cmdClose) |-> eventClose) else $error("command without event closure");
    AST_EVT_LEN: assert property (
        $fell(eventClose) |-> evtLen == CLOSE_CYCLES) else $error("event closure length");
    AST_CMD_LEN: assert property (
        $fell(|cmdClose) |-> cmdLen == CLOSE_CYCLES) else $error("command closure length");
    AST_SEP_QUIET: assert property (
        sepInhibitPin [*8] |-> !$rose(|cmdClose)) else $error("closure under inhibit");
    AST_SCAN_HOLD: assert property (
        (!dcScanPin && !qcStrobePin) [*5] |=> $stable(scanModeStat))
        else $error("mode status moved");
    AST_EN_HOLD: assert property (
        (!dcEnablePin && !dcInhibitPin) [*5] |=> $stable(outEnabledStat))
        else $error("enable status moved");
    AST_FREEZE: assert property (
        (countInhibitPin && !presetPin && !updatePin) [*6] |=> $stable(masterStages))
        else $error("frozen counter moved");
    AST_UPD: assert property (
        $rose(updatePin) |-> ##[2:6] !$stable(masterStages)) else $error("update ignored");
    AST_PRESET_SEQ: assert property (
        $fell(presetPin) |-> ##3 (seqStages == 0)) else $error("interval not cleared");
    AST_SQ_BOUND: assert property (
        sqHold <= 8'd133) else $error("square wave half period too long");
endmodule

bind sequencer_external_interface sequencer_external_interface_props #(
    .CLOSE_CYCLES(CLOSE_CYCLES)
) u_props (.ref_clk, .arst_n, .qcStrobePin, .qcFwdStrobe, .cmdClose, .eventClose,
    .sepInhibitPin, .dcScanPin, .scanModeStat, .dcEnablePin, .dcInhibitPin,
    .outEnabledStat, .countInhibitPin, .presetPin, .updatePin, .masterStages,
    .seqStages, .sq153k6);
`default_nettype wire

// ==== test/cmd_source_model.sv ====
// Pulse and word source standing for ground equipment and command receiver.
// Assumes tasks are entered just after a rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "seq_ext_regs.vh"

module cmd_source_model (
    input wire logic ref_clk, // System clock
    output wire logic presetPin, // Preset pulse
    output wire logic updatePin, // Update pulse
    output wire logic dcEnablePin, // Enable command
    output wire logic dcInhibitPin, // Inhibit command
    output wire logic dcScanPin, // Scan command
    output wire logic dcErasePin, // Erase command
    output wire logic dcBurnPin, // Burn enable command
    output logic qcStrobePin, // Word strobe
    output logic [`QC_W-1:0] qcWordPin // Word lines
);
    logic [6:0] pulseLines_reg = 7'h00;

    // Line order: preset, update, enable, inhibit, scan, erase, burn
    assign presetPin = pulseLines_reg[0];
    assign updatePin = pulseLines_reg[1];
    assign dcEnablePin = pulseLines_reg[2];
    assign dcInhibitPin = pulseLines_reg[3];
    assign dcScanPin = pulseLines_reg[4];
    assign dcErasePin = pulseLines_reg[5];
    assign dcBurnPin = pulseLines_reg[6];

    initial begin
        qcStrobePin = 1'b0;
        qcWordPin = 13'h0000;
    end

    // Three clocks high and low, past the two-clock minimum
    task automatic pulse(input int sel);
        @(posedge ref_clk);
        pulseLines_reg[sel] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        pulseLines_reg[sel] <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    // Word settles four clocks ahead; lines scrambled once released
    task automatic sendQc(input logic [`QC_W-1:0] w);
        @(posedge ref_clk);
        qcWordPin <= w;
        repeat (4) @(posedge ref_clk);
        qcStrobePin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        qcStrobePin <= 1'b0;
        qcWordPin <= ~w;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ==== test/sequencer_external_interface_test.sv ====
// Self-checking bench for the sequencer external interface.
// Assumes the pin source model and a short closure length for speed.
`timescale 1ns/1ps
`default_nettype none
`include "seq_ext_regs.vh"

module sequencer_external_interface_test;
    localparam [`CLOSE_CW-1:0] CLOSE = 23'd20;
    logic ref_clk = 1'b0;
    logic arst_n;
    logic [7:0] regAddr;
    logic [31:0] regWrData;
    logic regWr;
    logic regRd;
    logic countInhibitPin;
    logic supplyInhibitPin;
    logic sepInhibitPin;
    wire presetPin, updatePin, dcEnablePin, dcInhibitPin, dcScanPin, dcErasePin, dcBurnPin;
    wire qcStrobePin, qcFwdStrobe, eventClose, sq1pps, sq38k4, sq153k6;
    wire scanModeStat, outEnabledStat, supplyOff;
    wire [12:0] qcWordPin, qcFwdWord;
    wire [6:0] cmdClose;
    wire [31:0] regRdData;
    wire [25:0] masterStages;
    wire [17:0] seqStages;
    logic [12:0] fwdWord;
    int fwdCnt = 0;
    int errCount = 0;
    int totalChecks = 0;

    always #12.5 ref_clk = ~ref_clk;

    sequencer_external_interface #(.CLOSE_CYCLES(CLOSE)) u_dut (.ref_clk, .arst_n,
        .regAddr, .regWrData, .regWr, .regRd, .regRdData, .countInhibitPin, .presetPin,
        .updatePin, .supplyInhibitPin, .dcEnablePin, .dcInhibitPin, .dcScanPin, .dcErasePin,
        .dcBurnPin, .qcStrobePin, .qcWordPin, .sepInhibitPin, .qcFwdWord, .qcFwdStrobe,
        .cmdClose, .eventClose, .sq1pps, .sq38k4, .sq153k6, .scanModeStat, .outEnabledStat,
        .supplyOff, .masterStages, .seqStages);

    cmd_source_model u_far (.ref_clk, .presetPin, .updatePin, .dcEnablePin, .dcInhibitPin,
        .dcScanPin, .dcErasePin, .dcBurnPin, .qcStrobePin, .qcWordPin);

    // Forward strobe lasts one cycle, so catch it here
    always @(posedge ref_clk) begin
        if (qcFwdStrobe === 1'b1) begin
            fwdWord <= qcFwdWord;
            fwdCnt <= fwdCnt + 1;
        end
    end

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdCheck(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
        cmp(what, e, d);
        @(posedge ref_clk);
    endtask

    // Even parity over all thirteen bits makes a valid word
    function automatic logic [12:0] mkw(input logic [2:0] dest, input logic burn);
        mkw = {^{burn, dest, 8'h03}, burn, dest, 8'h03};
    endfunction

    // Waits for an event closure, then measures it and its command lines
    task automatic checkFire(input logic [6:0] expMask, input int expLen);
        int n;
        int len;
        logic [6:0] mask;
        n = 0;
        len = 0;
        while (eventClose !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        mask = cmdClose;
        while (eventClose === 1'b1 && len < 200) begin
            len++;
            @(posedge ref_clk);
        end
        cmp("closure mask", {25'h0, expMask}, {25'h0, mask});
        cmp("closure length", expLen, len);
    endtask

    task automatic scanAndCheck(input logic [6:0] expMask, input int expLen);
        fork
            u_far.pulse(4);
            checkFire(expMask, expLen);
        join
    endtask

    task automatic closeOut;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        errCount++;
        closeOut;
    end

    initial begin
        int rises;
        int seen;
        logic p153;
        logic p38;
        arst_n <= 1'b0;
        regAddr <= 8'h00;
        regWrData <= 32'h0;
        regWr <= 1'b0;
        regRd <= 1'b0;
        countInhibitPin <= 1'b0;
        supplyInhibitPin <= 1'b0;
        sepInhibitPin <= 1'b0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rdCheck("status reset", `ADDR_STATUS, 32'h0);
        rdCheck("unmapped", 8'h14, 32'h0);
        regWrite(`ADDR_STATUS, 32'hffffffff);
        countInhibitPin <= 1'b1;
        regWrite(`ADDR_PRESET, 32'h00000100);
        rdCheck("status frozen", `ADDR_STATUS, 32'h10);
        u_far.pulse(0);
        rdCheck("master preset", `ADDR_MASTER, 32'h100);
        cmp("interval cleared", 32'h0, {14'h0, seqStages});
        for (int i = 0; i < 3; i++) u_far.pulse(1);
        rdCheck("master updated", `ADDR_MASTER, 32'h103);
        cmp("master stages", 32'h103, {6'h0, masterStages});
        u_far.pulse(2);
        cmp("enabled", 32'h1, {31'h0, outEnabledStat});
        u_far.pulse(3);
        cmp("inhibited", 32'h0, {31'h0, outEnabledStat});
        u_far.pulse(2);
        u_far.sendQc(mkw(3'h0, 1'b0));
        cmp("forward word", {19'h0, mkw(3'h0, 1'b0)}, {19'h0, fwdWord});
        cmp("forward count", 32'h1, fwdCnt);
        cmp("update mode", 32'h0, {31'h0, scanModeStat});
        scanAndCheck(7'h01, CLOSE);
        cmp("scan mode", 32'h1, {31'h0, scanModeStat});
        u_far.sendQc(mkw(3'h1, 1'b1));
        u_far.sendQc(mkw(3'h2, 1'b0));
        scanAndCheck(7'h04, CLOSE);
        u_far.pulse(6);
        u_far.sendQc(mkw(3'h1, 1'b1));
        scanAndCheck(7'h02, CLOSE);
        sepInhibitPin <= 1'b1;
        u_far.sendQc(mkw(3'h4, 1'b0));
        scanAndCheck(7'h00, 0);
        sepInhibitPin <= 1'b0;
        u_far.sendQc(mkw(3'h5, 1'b0) ^ 13'h1000);
        u_far.pulse(5);
        scanAndCheck(7'h00, 0);
        u_far.sendQc(mkw(3'h7, 1'b0));
        scanAndCheck(7'h00, CLOSE);
        rdCheck("status running", `ADDR_STATUS, 32'h53);
        rises = 0;
        seen = 0;
        p153 = sq153k6;
        p38 = sq38k4;
        for (int i = 0; i < 3000; i++) begin
            @(posedge ref_clk);
            if (sq153k6 === 1'b1 && p153 === 1'b0 && seen == 1) rises++;
            if (sq38k4 === 1'b1 && p38 === 1'b0) seen++;
            p153 = sq153k6;
            p38 = sq38k4;
        end
        cmp("fast periods per slow", 32'h4, rises);
        supplyInhibitPin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        cmp("supply off", 32'h1, {31'h0, supplyOff});
        // Second preset halts the running interval counter and reloads the main one
        u_far.pulse(0);
        rdCheck("status halted", `ADDR_STATUS, 32'h33);
        rdCheck("master reloaded", `ADDR_MASTER, 32'h100);
        cmp("pps first half", 32'h1, {31'h0, sq1pps});
        closeOut;
    end
endmodule
`default_nettype wire
